// >>> bench/cvta_adc_model.sv
// Measurement engine model streaming cell results and scan ends
`timescale 1ns/1ps
module cvta_adc_model
    import cvta_pkg::*;
(
    input  wire logic   sys_clk,
    output cvta_result_s result,
    output logic         scan_done
);
    initial begin
        result = '0;
        scan_done = 1'b0;
    end
    // One result strobe, then idle with data lines inverted
    task automatic send(input logic [CH_W-1:0] c, input logic b, input logic [DATA_W-1:0] v);
        @(posedge sys_clk);
        result <= '{1'b1, c, b, v};
        @(posedge sys_clk);
        result <= '{1'b0, ~c, ~b, ~v};
        @(posedge sys_clk);
    endtask
    task automatic scan();
        @(posedge sys_clk);
        scan_done <= 1'b1;
        @(posedge sys_clk);
        scan_done <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

// >>> bench/cvta_properties.sv
// Port-level checker for the cell voltage threshold alert block
`timescale 1ns/1ps
module cvta_properties
    import cvta_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire cvta_result_s      result,
    input wire logic              scan_done,
    input wire logic              cell_overvolt_alert,
    input wire logic              cell_undervolt_alert,
    input wire logic              cell_spread_alert
);
    // ==========
    // Shadow set limits
    logic [DATA_W-1:0] uov_q;
    logic [DATA_W-1:0] uuv_q;
    logic [DATA_W-1:0] bov_q;
    logic              wr;
    assign wr = psel && penable && pready && pwrite;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            uov_q <= LIM_FULL;
            uuv_q <= LIM_ZERO;
            bov_q <= LIM_FULL;
        end else if (wr) begin
            if (paddr[7:2] == IDX_UNI_OV_SET) uov_q <= pwdata[LIM_MSB:LIM_LSB];
            if (paddr[7:2] == IDX_UNI_UV_SET) uuv_q <= pwdata[LIM_MSB:LIM_LSB];
            if (paddr[7:2] == IDX_BI_OV_SET) bov_q <= pwdata[LIM_MSB:LIM_LSB];
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    spread_hold_a: assert property (!scan_done |=> $stable(cell_spread_alert))
        else $error("spread alert moved without scan end");
    ov_cause_a: assert property ($changed(cell_overvolt_alert) |-> $past(result.valid))
        else $error("overvoltage alert moved without result");
    high_channel_a: assert property (result.valid && result.channel >= CELL_N
        |=> $stable(cell_overvolt_alert) && $stable(cell_undervolt_alert))
        else $error("channel above range changed alerts");
    uni_ov_set_a: assert property (result.valid && !result.bipolar &&
        result.channel < CELL_N && result.code > uov_q |=> cell_overvolt_alert)
        else $error("unipolar overvoltage not raised");
    uni_uv_set_a: assert property (result.valid && !result.bipolar &&
        result.channel < CELL_N && result.code < uuv_q |=> cell_undervolt_alert)
        else $error("unipolar undervoltage not raised");
    bi_ov_set_a: assert property (result.valid && result.bipolar &&
        result.channel < CELL_N && bov_q != LIM_FULL &&
        $signed(result.code) > $signed(bov_q) |=> cell_overvolt_alert)
        else $error("bipolar overvoltage not raised");
endmodule
bind cvta_top cvta_properties cvta_properties_i (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .result(result), .scan_done(scan_done),
    .cell_overvolt_alert(cell_overvolt_alert),
    .cell_undervolt_alert(cell_undervolt_alert),
    .cell_spread_alert(cell_spread_alert));

// >>> bench/cvta_top_tb.sv
// Self-checking bench for the cell voltage threshold alert block
`timescale 1ns/1ps
module cvta_top_tb
    import cvta_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              reset = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic [31:0]       rd;
    logic              pready, pslverr, er, scan_done, ov, uv, sp, irq;
    cvta_result_s      result;
    int                fail_count = 0;
    int                checks_done = 0;
    logic [DATA_W-1:0] rst [9] = '{14'h3fff, 14'h3fff, 14'h0000, 14'h0000, 14'h3fff,
                                   14'h3fff, 14'h3fff, 14'h0000, 14'h0000};
    always #5 sys_clk = ~sys_clk;
    cvta_top cvta_top_i (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .result(result), .scan_done(scan_done),
        .cell_overvolt_alert(ov), .cell_undervolt_alert(uv),
        .cell_spread_alert(sp), .irq(irq));
    cvta_adc_model cvta_adc_model_i (.sys_clk(sys_clk), .result(result), .scan_done(scan_done));
    // ==========
    // Compare and bus tasks
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic flg(input string nm, input logic e, input logic g);
        chk(nm, {31'b0, e}, {31'b0, g});
    endtask
    task automatic apb(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            flg("pready", 1'b1, pready);
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [IDX_W-1:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic lim(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] v);
        apb(1'b1, i, {16'h0000, v, 2'b00});
    endtask
    task automatic step(input logic [CH_W-1:0] c, input logic b, input logic [DATA_W-1:0] v,
                        input logic eo, input logic eu);
        cvta_adc_model_i.send(c, b, v);
        flg("ov alert", eo, ov);
        flg("uv alert", eu, uv);
    endtask
    task automatic scan3(input logic [DATA_W-1:0] hi, input logic e);
        cvta_adc_model_i.send(4'h4, 1'b0, 14'h01f4);
        cvta_adc_model_i.send(4'h5, 1'b0, hi);
        cvta_adc_model_i.send(4'h6, 1'b1, 14'h3000);
        cvta_adc_model_i.scan();
        flg("spread", e, sp);
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            rchk("limit reset", IDX_W'(IDX_UNI_OV_CLR + k), {16'h0000, rst[k], 2'b00});
        end
        apb(1'b0, 6'h3f, 32'h0000_0000);
        flg("slverr", 1'b1, er);
        step(4'h0, 1'b0, 14'h0000, 1'b0, 1'b0);
        apb(1'b1, IDX_UNI_UV_SET, 32'hffff_ffff);
        rchk("uv set", IDX_UNI_UV_SET, 32'h0000_fffc);
        lim(IDX_UNI_UV_CLR, 14'h00c8);
        lim(IDX_UNI_UV_SET, 14'h0064);
        lim(IDX_UNI_OV_SET, 14'h03e8);
        lim(IDX_UNI_OV_CLR, 14'h0384);
        step(4'h0, 1'b0, 14'h0063, 1'b0, 1'b1);
        step(4'h0, 1'b0, 14'h0096, 1'b0, 1'b1);
        step(4'h0, 1'b0, 14'h00c8, 1'b0, 1'b0);
        step(4'h1, 1'b0, 14'h03e8, 1'b0, 1'b0);
        step(4'h1, 1'b0, 14'h03e9, 1'b1, 1'b0);
        step(4'h1, 1'b0, 14'h03b6, 1'b1, 1'b0);
        step(4'he, 1'b0, 14'h0032, 1'b1, 1'b0);
        step(4'h1, 1'b0, 14'h0384, 1'b0, 1'b0);
        step(4'h2, 1'b1, 14'h1fff, 1'b0, 1'b0);
        lim(IDX_BI_OV_CLR, 14'h0032);
        lim(IDX_BI_OV_SET, 14'h0064);
        step(4'h2, 1'b1, 14'h0065, 1'b1, 1'b0);
        step(4'h2, 1'b1, 14'h3fff, 1'b0, 1'b0);
        lim(IDX_BI_UV_SET, 14'h3f9c);
        lim(IDX_BI_UV_CLR, 14'h3fce);
        step(4'h3, 1'b1, 14'h3f9b, 1'b0, 1'b1);
        step(4'h3, 1'b1, 14'h3fb0, 1'b0, 1'b1);
        step(4'h3, 1'b1, 14'h3fce, 1'b0, 1'b0);
        lim(IDX_MISMATCH, 14'h0064);
        cvta_adc_model_i.scan();
        scan3(14'h0258, 1'b0);
        apb(1'b1, IDX_POL_CTRL, 32'h0000_0001);
        rchk("polarity", IDX_POL_CTRL, 32'h0000_0001);
        scan3(14'h0258, 1'b1);
        apb(1'b1, IDX_POL_CTRL, 32'h0000_0000);
        scan3(14'h0259, 1'b1);
        apb(1'b1, IDX_SPAN, 32'hffff_ffff);
        flg("slverr", 1'b0, er);
        rchk("span", IDX_SPAN, 32'h0000_0065);
        step(4'h6, 1'b1, 14'h0000, 1'b0, 1'b0);
        apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0007);
        rchk("irq status", IDX_IRQ_STATUS, 32'h0000_0000);
        apb(1'b1, IDX_IRQ_MASK, 32'h0000_0001);
        rchk("irq mask", IDX_IRQ_MASK, 32'h0000_0001);
        step(4'h1, 1'b0, 14'h03e9, 1'b1, 1'b0);
        repeat (2) @(posedge sys_clk);
        flg("irq", 1'b1, irq);
        step(4'h0, 1'b0, 14'h0032, 1'b1, 1'b1);
        rchk("cell alerts", IDX_CELL_ALERT, 32'h0001_0002);
        apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        flg("irq", 1'b0, irq);
        rchk("irq status", IDX_IRQ_STATUS, 32'h0000_0002);
        complete_run();
    end
endmodule

// >>> logic/cvta_spread.sv
// Running maximum and minimum of the results of one cell scan
`timescale 1ns/1ps
module cvta_spread
    import cvta_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire cvta_result_s res,
    input  wire logic         include_bipolar,
    input  wire logic         scan_done,
    output logic [SPAN_W-1:0] span,
    output logic              span_ok
);

    cvta_spread_e             state_q;
    logic signed [DATA_W:0]   max_q;
    logic signed [DATA_W:0]   min_q;
    logic signed [DATA_W:0]   max_d;
    logic signed [DATA_W:0]   min_d;
    logic signed [DATA_W:0]   val;
    logic                     take;
    logic signed [SPAN_W-1:0] diff;

    // ==========================================================
    // Candidate extremes including the current result
    always_comb begin
        val  = res.bipolar ? $signed({res.code[DATA_W-1], res.code})
                           : $signed({1'b0, res.code});
        take = res.valid && (include_bipolar || !res.bipolar);
        max_d = max_q;
        min_d = min_q;
        span_ok = (state_q == SPR_TRACK);
        if (take) begin
            span_ok = 1'b1;
            if (state_q == SPR_EMPTY || val > max_q) begin
                max_d = val;
            end
            if (state_q == SPR_EMPTY || val < min_q) begin
                min_d = val;
            end
        end
        diff = SPAN_W'(max_d) - SPAN_W'(min_d);
        span = diff;
    end

    // ==========================================================
    // Tracker state, emptied at the end of every scan
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q <= SPR_EMPTY;
            max_q   <= '0;
            min_q   <= '0;
        end else begin
            max_q <= max_d;
            min_q <= min_d;
            case (state_q)
                SPR_EMPTY: begin
                    if (take && !scan_done) begin
                        state_q <= SPR_TRACK;
                    end
                end
                SPR_TRACK: begin
                    if (scan_done) begin
                        state_q <= SPR_EMPTY;
                    end
                end
                default: begin
                    state_q <= SPR_EMPTY;
                end
            endcase
        end
    end

endmodule

// >>> logic/cvta_top.sv
// Cell voltage threshold alerts with APB register file and interrupt
//
// What this block does
// - Unipolar result below set limit raises undervoltage
// - Unipolar undervoltage set limit zero never trips
// - Scan spread above limit raises mismatch alert
// - Selector includes unipolar channels only, or all
// - Bipolar result at/below clear drops overvoltage
// - Bipolar result above set limit raises overvoltage
// - Bipolar overvoltage set at full scale disables
// - Bipolar result at/above clear drops undervoltage
// - Bipolar limits compared as signed values
// - Limits sit in bits 15:2, low bits zero
// - Unipolar result above set limit raises overvoltage
// - Unipolar result at/below clear drops overvoltage
// - Unipolar result at/above clear drops undervoltage
`timescale 1ns/1ps
module cvta_top
    import cvta_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire cvta_result_s      result,
    input  wire logic              scan_done,
    output logic                   cell_overvolt_alert,
    output logic                   cell_undervolt_alert,
    output logic                   cell_spread_alert,
    output logic                   irq
);

    cvta_limits_s        lim_q;
    logic                spread_polarity_select_q;
    logic [CELL_N-1:0]   ov_q;
    logic [CELL_N-1:0]   uv_q;
    logic [CELL_N-1:0]   ov_d;
    logic [CELL_N-1:0]   uv_d;
    logic                ov_alert_q;
    logic                uv_alert_q;
    logic                spread_alert_q;
    logic [SPAN_W-1:0]   span_last_q;
    logic [IRQ_W-1:0]    irq_status_q;
    logic [IRQ_W-1:0]    irq_mask_q;
    logic [IRQ_W-1:0]    irq_event;
    logic                irq_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [IDX_W-1:0]    idx;
    logic                bus_start;
    logic                bus_done;
    logic                wr_done;
    logic                spread_d;
    logic [SPAN_W-1:0]   span;
    logic                span_ok;
    cvta_trip_s          trip;

    // ==========================================================
    // Register map helpers
    function automatic logic is_mapped(input logic [IDX_W-1:0] i);
        case (i)
            IDX_UNI_OV_CLR, IDX_UNI_OV_SET, IDX_UNI_UV_CLR, IDX_UNI_UV_SET,
            IDX_MISMATCH, IDX_BI_OV_CLR, IDX_BI_OV_SET, IDX_BI_UV_CLR,
            IDX_BI_UV_SET, IDX_POL_CTRL, IDX_CELL_ALERT, IDX_IRQ_STATUS,
            IDX_IRQ_MASK, IDX_SPAN: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    function automatic logic [31:0] place_limit(input logic [DATA_W-1:0] v);
        place_limit = 32'h0000_0000;
        place_limit[LIM_MSB:LIM_LSB] = v;
    endfunction

    // ==========================================================
    // APB handshake: one wait state, answer from flip-flops
    assign idx       = paddr[ADDR_W-1:2];
    assign bus_start = psel && penable && !pready_q;
    assign bus_done  = psel && penable && pready_q;
    assign wr_done   = bus_done && pwrite && is_mapped(idx);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= bus_start;
            pslverr_q <= bus_start && !is_mapped(idx);
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (bus_start) begin
            prdata_q <= 32'h0000_0000;
            if (!pwrite) begin
                case (idx)
                    IDX_UNI_OV_CLR: prdata_q <= place_limit(lim_q.uni_ov_clear_limit);
                    IDX_UNI_OV_SET: prdata_q <= place_limit(lim_q.uni_ov_set_limit);
                    IDX_UNI_UV_CLR: prdata_q <= place_limit(lim_q.uni_uv_clear_limit);
                    IDX_UNI_UV_SET: prdata_q <= place_limit(lim_q.uni_uv_set_limit);
                    IDX_MISMATCH:   prdata_q <= place_limit(lim_q.mismatch_limit);
                    IDX_BI_OV_CLR:  prdata_q <= place_limit(lim_q.bi_ov_clear_limit);
                    IDX_BI_OV_SET:  prdata_q <= place_limit(lim_q.bi_ov_set_limit);
                    IDX_BI_UV_CLR:  prdata_q <= place_limit(lim_q.bi_uv_clear_limit);
                    IDX_BI_UV_SET:  prdata_q <= place_limit(lim_q.bi_uv_set_limit);
                    IDX_POL_CTRL:   prdata_q[POL_SEL_BIT] <= spread_polarity_select_q;
                    IDX_CELL_ALERT: begin
                        prdata_q[CELL_N-1:0]                   <= ov_q;
                        prdata_q[UV_ALERT_LSB+CELL_N-1:UV_ALERT_LSB] <= uv_q;
                    end
                    IDX_IRQ_STATUS: prdata_q[IRQ_W-1:0] <= irq_status_q;
                    IDX_IRQ_MASK:   prdata_q[IRQ_W-1:0] <= irq_mask_q;
                    IDX_SPAN:       prdata_q[SPAN_W-1:0] <= span_last_q;
                    default:        prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Limit and control registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            lim_q.uni_ov_clear_limit <= LIM_FULL;
            lim_q.uni_ov_set_limit   <= LIM_FULL;
            lim_q.uni_uv_clear_limit <= LIM_ZERO;
            lim_q.uni_uv_set_limit   <= LIM_ZERO;
            lim_q.mismatch_limit     <= LIM_FULL;
            lim_q.bi_ov_clear_limit  <= LIM_FULL;
            lim_q.bi_ov_set_limit    <= LIM_FULL;
            lim_q.bi_uv_clear_limit  <= LIM_ZERO;
            lim_q.bi_uv_set_limit    <= LIM_ZERO;
        end else if (wr_done) begin
            case (idx)
                IDX_UNI_OV_CLR: lim_q.uni_ov_clear_limit <= pwdata[LIM_MSB:LIM_LSB];
                IDX_UNI_OV_SET: lim_q.uni_ov_set_limit   <= pwdata[LIM_MSB:LIM_LSB];
                IDX_UNI_UV_CLR: lim_q.uni_uv_clear_limit <= pwdata[LIM_MSB:LIM_LSB];
                IDX_UNI_UV_SET: lim_q.uni_uv_set_limit   <= pwdata[LIM_MSB:LIM_LSB];
                IDX_MISMATCH:   lim_q.mismatch_limit     <= pwdata[LIM_MSB:LIM_LSB];
                IDX_BI_OV_CLR:  lim_q.bi_ov_clear_limit  <= pwdata[LIM_MSB:LIM_LSB];
                IDX_BI_OV_SET:  lim_q.bi_ov_set_limit    <= pwdata[LIM_MSB:LIM_LSB];
                IDX_BI_UV_CLR:  lim_q.bi_uv_clear_limit  <= pwdata[LIM_MSB:LIM_LSB];
                IDX_BI_UV_SET:  lim_q.bi_uv_set_limit    <= pwdata[LIM_MSB:LIM_LSB];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            spread_polarity_select_q <= 1'b0;
            irq_mask_q               <= '0;
        end else if (wr_done) begin
            if (idx == IDX_POL_CTRL) begin
                spread_polarity_select_q <= pwdata[POL_SEL_BIT];
            end
            if (idx == IDX_IRQ_MASK) begin
                irq_mask_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ==========================================================
    // Threshold comparison of the incoming result
    cvta_trip u_trip (
        .res  (result),
        .lim  (lim_q),
        .trip (trip)
    );

    // ==========================================================
    // Per-cell alert state with hysteresis
    generate
        for (genvar c = 0; c < CELL_N; c++) begin : g_cell
            always_comb begin
                ov_d[c] = ov_q[c];
                uv_d[c] = uv_q[c];
                if (result.valid && result.channel == CH_W'(c)) begin
                    if (trip.ov_set) begin
                        ov_d[c] = 1'b1;
                    end else if (trip.ov_clr) begin
                        ov_d[c] = 1'b0;
                    end
                    if (trip.uv_set) begin
                        uv_d[c] = 1'b1;
                    end else if (trip.uv_clr) begin
                        uv_d[c] = 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ov_q <= '0;
            uv_q <= '0;
        end else begin
            ov_q <= ov_d;
            uv_q <= uv_d;
        end
    end

    // ==========================================================
    // Spread of the scan
    cvta_spread u_spread (
        .sys_clk         (sys_clk),
        .reset           (reset),
        .res             (result),
        .include_bipolar (spread_polarity_select_q),
        .scan_done       (scan_done),
        .span            (span),
        .span_ok         (span_ok)
    );

    assign spread_d = span_ok && (span > SPAN_W'(lim_q.mismatch_limit));

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            spread_alert_q <= 1'b0;
            span_last_q    <= '0;
        end else if (scan_done) begin
            spread_alert_q <= spread_d;
            span_last_q    <= span_ok ? span : '0;
        end
    end

    // ==========================================================
    // Alert outputs
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ov_alert_q <= 1'b0;
            uv_alert_q <= 1'b0;
        end else begin
            ov_alert_q <= |ov_d;
            uv_alert_q <= |uv_d;
        end
    end

    assign cell_overvolt_alert  = ov_alert_q;
    assign cell_undervolt_alert = uv_alert_q;
    assign cell_spread_alert    = spread_alert_q;

    // ==========================================================
    // Interrupt status, mask and output
    always_comb begin
        irq_event             = '0;
        irq_event[IRQ_OV]     = (|ov_d) && !ov_alert_q;
        irq_event[IRQ_UV]     = (|uv_d) && !uv_alert_q;
        irq_event[IRQ_SPREAD] = scan_done && spread_d && !spread_alert_q;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_status_q <= '0;
        end else begin
            if (wr_done && idx == IDX_IRQ_STATUS) begin
                irq_status_q <= (irq_status_q & ~pwdata[IRQ_W-1:0]) | irq_event;
            end else begin
                irq_status_q <= irq_status_q | irq_event;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    assign irq = irq_q;

endmodule

// >>> logic/cvta_trip.sv
// Set and clear comparisons of one cell result against the limit set of its polarity
`timescale 1ns/1ps
module cvta_trip
    import cvta_pkg::*;
(
    input  wire cvta_result_s res,
    input  wire cvta_limits_s lim,
    output cvta_trip_s        trip
);

    logic signed [DATA_W-1:0] s_code;

    always_comb begin
        s_code = $signed(res.code);
        if (res.bipolar) begin
            trip.ov_set = (s_code > $signed(lim.bi_ov_set_limit))
                          && (lim.bi_ov_set_limit != LIM_FULL);
            trip.ov_clr = s_code <= $signed(lim.bi_ov_clear_limit);
            trip.uv_set = (s_code < $signed(lim.bi_uv_set_limit))
                          && (lim.bi_uv_set_limit != LIM_ZERO);
            trip.uv_clr = s_code >= $signed(lim.bi_uv_clear_limit);
        end else begin
            trip.ov_set = (res.code > lim.uni_ov_set_limit)
                          && (lim.uni_ov_set_limit != LIM_FULL);
            trip.ov_clr = res.code <= lim.uni_ov_clear_limit;
            trip.uv_set = res.code < lim.uni_uv_set_limit;
            trip.uv_clr = res.code >= lim.uni_uv_clear_limit;
        end
    end

endmodule

// >>> pkg/cvta_pkg.sv
// Package with constants and carriers for the cell voltage threshold alert block
package cvta_pkg;

    // ==========================================================
    // Widths
    localparam int CELL_N  = 14;
    localparam int DATA_W  = 14;
    localparam int CH_W    = 4;
    localparam int IDX_W   = 6;
    localparam int ADDR_W  = 8;
    localparam int SPAN_W  = 16;
    localparam int IRQ_W   = 3;

    // ==========================================================
    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_UNI_OV_CLR  = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_UNI_OV_SET  = 6'h20;
    localparam logic [IDX_W-1:0] IDX_UNI_UV_CLR  = 6'h21;
    localparam logic [IDX_W-1:0] IDX_UNI_UV_SET  = 6'h22;
    localparam logic [IDX_W-1:0] IDX_MISMATCH    = 6'h23;
    localparam logic [IDX_W-1:0] IDX_BI_OV_CLR   = 6'h24;
    localparam logic [IDX_W-1:0] IDX_BI_OV_SET   = 6'h25;
    localparam logic [IDX_W-1:0] IDX_BI_UV_CLR   = 6'h26;
    localparam logic [IDX_W-1:0] IDX_BI_UV_SET   = 6'h27;
    localparam logic [IDX_W-1:0] IDX_POL_CTRL    = 6'h30;
    localparam logic [IDX_W-1:0] IDX_CELL_ALERT  = 6'h31;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 6'h32;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 6'h33;
    localparam logic [IDX_W-1:0] IDX_SPAN        = 6'h34;

    // ==========================================================
    // Field positions
    localparam int LIM_LSB       = 2;
    localparam int LIM_MSB       = 15;
    localparam int POL_SEL_BIT   = 0;
    localparam int UV_ALERT_LSB  = 16;
    localparam int IRQ_OV        = 0;
    localparam int IRQ_UV        = 1;
    localparam int IRQ_SPREAD    = 2;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] LIM_FULL = 14'h3fff;
    localparam logic [DATA_W-1:0] LIM_ZERO = 14'h0000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic              valid;
        logic [CH_W-1:0]   channel;
        logic              bipolar;
        logic [DATA_W-1:0] code;
    } cvta_result_s;

    typedef struct packed {
        logic [DATA_W-1:0] uni_ov_clear_limit;
        logic [DATA_W-1:0] uni_ov_set_limit;
        logic [DATA_W-1:0] uni_uv_clear_limit;
        logic [DATA_W-1:0] uni_uv_set_limit;
        logic [DATA_W-1:0] mismatch_limit;
        logic [DATA_W-1:0] bi_ov_clear_limit;
        logic [DATA_W-1:0] bi_ov_set_limit;
        logic [DATA_W-1:0] bi_uv_clear_limit;
        logic [DATA_W-1:0] bi_uv_set_limit;
    } cvta_limits_s;

    typedef struct packed {
        logic ov_set;
        logic ov_clr;
        logic uv_set;
        logic uv_clr;
    } cvta_trip_s;

    typedef enum logic {SPR_EMPTY, SPR_TRACK} cvta_spread_e;

endpackage
